// [shared/ilmc_pkg.sv]
/*
  Constants, types and helpers shared by the two-wire line and mode control block.
  Assumes one 125 MHz core clock and byte-wide registers placed on 32-bit AXI4-Lite words.
*/
package ilmc_pkg;

  localparam int unsigned ILMC_ADDR_W = 5;

  localparam logic [4:0] OFS_BUS_CONTROL_TWO = 5'h00;
  localparam logic [4:0] OFS_BUS_MODE = 5'h04;
  localparam logic [4:0] OFS_FRAME_CTRL = 5'h08;
  localparam logic [4:0] OFS_FRAME_DATA = 5'h0C;
  localparam logic [4:0] OFS_FRAME_STAT = 5'h10;

  localparam int unsigned B2_BUS_BUSY = 7;
  localparam int unsigned B2_ISSUE_OFF = 6;
  localparam int unsigned B2_LEVEL = 5;
  localparam int unsigned B2_LEVEL_WP = 4;
  localparam int unsigned B2_MONITOR = 3;
  localparam int unsigned B2_RSVD_HI = 2;
  localparam int unsigned B2_CTL_RST = 1;
  localparam int unsigned B2_RSVD_LO = 0;

  localparam int unsigned MD_ORDER = 7;
  localparam int unsigned MD_WAIT = 6;
  localparam int unsigned MD_RSVD_HI = 5;
  localparam int unsigned MD_RSVD_LO = 4;
  localparam int unsigned MD_BC_WP = 3;
  localparam int unsigned MD_BC_LSB = 0;

  localparam int unsigned CT_MASTER = 0;
  localparam int unsigned CT_TWO_WIRE = 1;
  localparam int unsigned CT_START = 2;
  localparam int unsigned SR_BUSY = 0;
  localparam int unsigned SR_ACK = 1;

  localparam logic RST_LEVEL = 1'b1;
  localparam logic RST_CTL_RST = 1'b0;
  localparam logic RST_ORDER = 1'b0;
  localparam logic RST_WAIT = 1'b0;
  localparam logic [2:0] RST_BIT_COUNT = 3'h0;
  localparam logic RST_MASTER = 1'b0;
  localparam logic RST_TWO_WIRE = 1'b1;

  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned HALF_BIT_NS = 80;
  localparam int unsigned HALF_BIT_CYCLES = HALF_BIT_NS / CLK_PERIOD_NS;
  localparam int unsigned WAIT_PERIODS = 2;
  localparam logic [2:0] WAIT_TICKS = 3'(WAIT_PERIODS * 2);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ENG_IDLE = 3'h0,
    ENG_LOW = 3'h1,
    ENG_HIGH = 3'h3,
    ENG_WAIT = 3'h2,
    ENG_SLAVE = 3'h6
  } ilmc_eng_t;

  typedef struct packed {
    logic en;
    logic [4:0] addr;
    logic [7:0] data;
  } ilmc_wreq_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } ilmc_lines_t;

  function automatic logic ilmc_mapped(input logic [4:0] a);
    return (a == OFS_BUS_CONTROL_TWO) || (a == OFS_BUS_MODE) || (a == OFS_FRAME_CTRL) ||
           (a == OFS_FRAME_DATA) || (a == OFS_FRAME_STAT);
  endfunction : ilmc_mapped

endpackage : ilmc_pkg

// [src/ilmc_sync.sv]
/*
  Two-flop synchroniser for the bus line levels.
  Assumes inputs come from pins outside the core clock domain.
*/
`timescale 1ns/1ps
module ilmc_sync
  import ilmc_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire ilmc_pkg::ilmc_lines_t d,
  output ilmc_pkg::ilmc_lines_t q
);
  typedef struct packed {
    ilmc_lines_t s1;
    ilmc_lines_t s2;
  } ilmc_sync_st_t;

  ilmc_sync_st_t st_ff;
  ilmc_sync_st_t nxt_st;

  always_comb
  begin
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      st_ff <= '{s1: '{scl: 1'b1, sda: 1'b1}, s2: '{scl: 1'b1, sda: 1'b1}};
    else
      st_ff <= nxt_st;
  end

  assign q = st_ff.s2;
endmodule : ilmc_sync

// [src/ilmc_axil.sv]
/*
  AXI4-Lite slave front end: one write and one read at a time.
  Assumes the parent supplies read data combinationally from rd_addr.
*/
`timescale 1ns/1ps
module ilmc_axil
  import ilmc_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [ILMC_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ILMC_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output ilmc_pkg::ilmc_wreq_t wreq,
  output logic [4:0] rd_addr,
  input wire logic [7:0] rd_byte
);
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [4:0] waddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic wr_en;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rpend;
    logic [4:0] raddr;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } ilmc_axil_st_t;

  ilmc_axil_st_t st_ff;
  ilmc_axil_st_t nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.wr_en = 1'b0;
    if (awvalid && st_ff.awready)
    begin
      nxt_st.awready = 1'b0;
      nxt_st.aw_got = 1'b1;
      nxt_st.waddr = awaddr;
    end
    if (wvalid && st_ff.wready)
    begin
      nxt_st.wready = 1'b0;
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = wdata[7:0];
      nxt_st.wstrb0 = wstrb[0];
    end
    if (st_ff.aw_got && st_ff.w_got)
    begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.wr_en = st_ff.wstrb0 && ilmc_mapped(st_ff.waddr);
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = ilmc_mapped(st_ff.waddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (st_ff.bvalid && bready)
    begin
      nxt_st.bvalid = 1'b0;
      nxt_st.awready = 1'b1;
      nxt_st.wready = 1'b1;
    end
    if (arvalid && st_ff.arready)
    begin
      nxt_st.arready = 1'b0;
      nxt_st.rpend = 1'b1;
      nxt_st.raddr = araddr;
    end
    if (st_ff.rpend)
    begin
      nxt_st.rpend = 1'b0;
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = ilmc_mapped(st_ff.raddr) ? rd_byte : 8'h00;
      nxt_st.rresp = ilmc_mapped(st_ff.raddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (st_ff.rvalid && rready)
    begin
      nxt_st.rvalid = 1'b0;
      nxt_st.arready = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_ff <= '0;
      st_ff.awready <= 1'b1;
      st_ff.wready <= 1'b1;
      st_ff.arready <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  assign awready = st_ff.awready;
  assign wready = st_ff.wready;
  assign bvalid = st_ff.bvalid;
  assign bresp = st_ff.bresp;
  assign arready = st_ff.arready;
  assign rvalid = st_ff.rvalid;
  assign rdata = {24'h000000, st_ff.rdata};
  assign rresp = st_ff.rresp;
  assign wreq = '{en: st_ff.wr_en, addr: st_ff.waddr, data: st_ff.wdata};
  assign rd_addr = st_ff.raddr;
endmodule : ilmc_axil

// [src/ilmc_top.sv]
/*
  Two-wire line and mode control: data-line forcing, clock monitor, control reset,
  bit order, master wait insertion, protected bit count, and a small frame shifter.
  Assumes open-drain SCL/SDA with external pull-ups; the enables are resolved outside.
*/
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module ilmc_top
  import ilmc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = HALF_BIT_CYCLES
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [ILMC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ILMC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  import ilmc_pkg::*;

  typedef struct packed {
    logic level;
    logic ctl_rst;
    logic order;
    logic wait_en;
    logic [2:0] bc;
    logic master;
    logic two_wire;
    ilmc_eng_t eng;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] rx;
    logic ack;
    logic [2:0] wcnt;
    logic [7:0] div;
    logic scl_prev;
    logic drv_scl;
    logic drv_sda;
    logic scl_oe;
    logic sda_oe;
  } ilmc_st_t;

  localparam logic [7:0] TICK_RELOAD = 8'(TICK_CYCLES - 1);

  ilmc_st_t st_ff;
  ilmc_st_t nxt_st;
  ilmc_wreq_t wreq;
  ilmc_lines_t lines;
  logic [4:0] rd_addr;
  logic [7:0] rd_byte;

  ilmc_sync u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .d('{scl: scl_i, sda: sda_i}),
    .q(lines)
  );

  ilmc_axil u_axil (
    .core_clk(core_clk),
    .resetn(resetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wreq(wreq),
    .rd_addr(rd_addr),
    .rd_byte(rd_byte)
  );

  function automatic logic [3:0] frame_bits(input logic two_wire, input logic [2:0] bc);
    if (two_wire)
      return (bc == 3'h0) ? 4'h9 : 4'({1'b0, bc} + 4'h1);
    return (bc == 3'h0) ? 4'h8 : {1'b0, bc};
  endfunction : frame_bits

  function automatic logic [2:0] bits_to_field(input logic two_wire, input logic [3:0] n);
    if (two_wire)
      return (n >= 4'h9 || n == 4'h0) ? 3'h0 : 3'(n - 4'h1);
    return n[2:0];
  endfunction : bits_to_field

  function automatic logic [7:0] flip(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++)
      r[i] = v[7 - i];
    return r;
  endfunction : flip

  // Register read mux
  always_comb
  begin
    rd_byte = 8'h00;
    case (rd_addr)
      OFS_BUS_CONTROL_TWO:
      begin
        rd_byte[B2_BUS_BUSY] = (st_ff.eng != ENG_IDLE);
        rd_byte[B2_ISSUE_OFF] = 1'b1;
        rd_byte[B2_LEVEL] = st_ff.level;
        rd_byte[B2_LEVEL_WP] = 1'b1;
        rd_byte[B2_MONITOR] = !st_ff.scl_oe;
        rd_byte[B2_RSVD_HI] = 1'b1;
        rd_byte[B2_CTL_RST] = st_ff.ctl_rst;
        rd_byte[B2_RSVD_LO] = 1'b1;
      end
      OFS_BUS_MODE:
      begin
        rd_byte[MD_ORDER] = st_ff.order;
        rd_byte[MD_WAIT] = st_ff.wait_en;
        rd_byte[MD_RSVD_HI] = 1'b1;
        rd_byte[MD_RSVD_LO] = 1'b1;
        rd_byte[MD_BC_WP] = 1'b1;
        rd_byte[MD_BC_LSB +: 3] = (st_ff.eng != ENG_IDLE) ?
          bits_to_field(st_ff.two_wire, st_ff.cnt) : st_ff.bc;
      end
      OFS_FRAME_CTRL:
      begin
        rd_byte[CT_MASTER] = st_ff.master;
        rd_byte[CT_TWO_WIRE] = st_ff.two_wire;
      end
      OFS_FRAME_DATA:
        rd_byte = st_ff.order ? flip(st_ff.rx) : st_ff.rx;
      OFS_FRAME_STAT:
      begin
        rd_byte[SR_BUSY] = (st_ff.eng != ENG_IDLE);
        rd_byte[SR_ACK] = st_ff.ack;
      end
      default:
        rd_byte = 8'h00;
    endcase
  end

  // Register writes, frame engine and line drive
  always_comb
  begin
    logic tick;
    logic scl_rise;
    logic start;
    nxt_st = st_ff;
    tick = (st_ff.div == 8'h00);
    scl_rise = lines.scl && !st_ff.scl_prev;
    start = 1'b0;
    nxt_st.scl_prev = lines.scl;
    nxt_st.div = (tick || st_ff.eng == ENG_IDLE) ? TICK_RELOAD : 8'(st_ff.div - 8'h01);

    if (wreq.en)
    begin
      case (wreq.addr)
        OFS_BUS_CONTROL_TWO:
        begin
          if (!wreq.data[B2_LEVEL_WP])
            nxt_st.level = wreq.data[B2_LEVEL];
          nxt_st.ctl_rst = wreq.data[B2_CTL_RST];
        end
        OFS_BUS_MODE:
        begin
          nxt_st.order = wreq.data[MD_ORDER];
          nxt_st.wait_en = wreq.data[MD_WAIT];
          if (!wreq.data[MD_BC_WP])
            nxt_st.bc = wreq.data[MD_BC_LSB +: 3];
        end
        OFS_FRAME_CTRL:
        begin
          nxt_st.master = wreq.data[CT_MASTER];
          nxt_st.two_wire = wreq.data[CT_TWO_WIRE];
          start = wreq.data[CT_START] && (st_ff.eng == ENG_IDLE);
        end
        OFS_FRAME_DATA:
          if (st_ff.eng == ENG_IDLE)
            nxt_st.sh = st_ff.order ? flip(wreq.data) : wreq.data;
        default:
          nxt_st.level = st_ff.level;
      endcase
    end

    case (st_ff.eng)
      ENG_IDLE:
        if (start && !st_ff.ctl_rst)
        begin
          nxt_st.cnt = frame_bits(wreq.data[CT_TWO_WIRE], st_ff.bc);
          nxt_st.eng = wreq.data[CT_MASTER] ? ENG_LOW : ENG_SLAVE;
          nxt_st.drv_scl = wreq.data[CT_MASTER];
          nxt_st.div = TICK_RELOAD;
        end
      ENG_LOW:
      begin
        nxt_st.drv_sda = !(st_ff.two_wire && st_ff.cnt == 4'h1) && !st_ff.sh[7];
        if (tick)
        begin
          nxt_st.eng = ENG_HIGH;
          nxt_st.drv_scl = 1'b0;
        end
      end
      ENG_HIGH:
        // A slave holding SCL low stretches this phase
        if (tick && lines.scl)
        begin
          nxt_st.rx = {st_ff.rx[6:0], lines.sda};
          nxt_st.sh = {st_ff.sh[6:0], 1'b0};
          nxt_st.cnt = 4'(st_ff.cnt - 4'h1);
          nxt_st.drv_scl = 1'b1;
          if (st_ff.cnt == 4'h1)
          begin
            nxt_st.eng = ENG_IDLE;
            nxt_st.drv_scl = 1'b0;
            nxt_st.drv_sda = 1'b0;
            nxt_st.bc = 3'h0;
            if (st_ff.two_wire)
            begin
              nxt_st.ack = !lines.sda;
              nxt_st.rx = st_ff.rx;
            end
          end
          else if (st_ff.two_wire && st_ff.wait_en && st_ff.cnt == 4'h2)
          begin
            nxt_st.eng = ENG_WAIT;
            nxt_st.wcnt = WAIT_TICKS;
          end
          else
            nxt_st.eng = ENG_LOW;
        end
      ENG_WAIT:
        if (tick)
        begin
          nxt_st.wcnt = 3'(st_ff.wcnt - 3'h1);
          if (st_ff.wcnt == 3'h1)
            nxt_st.eng = ENG_LOW;
        end
      ENG_SLAVE:
        if (scl_rise)
        begin
          nxt_st.rx = {st_ff.rx[6:0], lines.sda};
          nxt_st.cnt = 4'(st_ff.cnt - 4'h1);
          if (st_ff.cnt == 4'h1)
          begin
            nxt_st.eng = ENG_IDLE;
            nxt_st.bc = 3'h0;
            if (st_ff.two_wire)
            begin
              nxt_st.ack = !lines.sda;
              nxt_st.rx = st_ff.rx;
            end
          end
        end
      default:
        nxt_st.eng = ENG_IDLE;
    endcase

    // Protocol reset clears only the engine, registers keep their values
    if (st_ff.ctl_rst)
    begin
      nxt_st.eng = ENG_IDLE;
      nxt_st.cnt = 4'h0;
      nxt_st.wcnt = 3'h0;
      nxt_st.drv_scl = 1'b0;
      nxt_st.drv_sda = 1'b0;
    end

    nxt_st.scl_oe = nxt_st.drv_scl;
    nxt_st.sda_oe = (nxt_st.eng == ENG_LOW || nxt_st.eng == ENG_HIGH ||
                     nxt_st.eng == ENG_WAIT) ? nxt_st.drv_sda : !nxt_st.level;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_ff <= '0;
      st_ff.level <= RST_LEVEL;
      st_ff.ctl_rst <= RST_CTL_RST;
      st_ff.order <= RST_ORDER;
      st_ff.wait_en <= RST_WAIT;
      st_ff.bc <= RST_BIT_COUNT;
      st_ff.master <= RST_MASTER;
      st_ff.two_wire <= RST_TWO_WIRE;
      st_ff.eng <= ENG_IDLE;
      st_ff.scl_prev <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  assign scl_oe = st_ff.scl_oe;
  assign sda_oe = st_ff.sda_oe;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
endmodule : ilmc_top

// [test/ilmc_sva.sv]
/*
  Checker for ilmc_top: bus handshake timing and fixed read bits.
  Bound to ilmc_top below; sees only its ports.
*/
`timescale 1ns/1ps
module ilmc_sva
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ilmc_pkg::ILMC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic scl_o,
  input wire logic sda_o
);
  import ilmc_pkg::*;
  logic [4:0] ra_ff;

  // Address of the read in flight
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
      ra_ff <= 5'h00;
    else if (s_axi_arvalid && s_axi_arready)
      ra_ff <= s_axi_araddr;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  lines_od_a: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("line output value not zero");
  wr_resp_a: assert property (aw_w_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response late");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  rd_lat_a: assert property (ar_taken |=> !s_axi_rvalid ##1 s_axi_rvalid)
    else $error("read data not two cycles after address");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  ctl_rsvd_a: assert property (s_axi_rvalid && ra_ff == 5'h00 |->
    s_axi_rdata[6] && s_axi_rdata[4] && s_axi_rdata[2] && s_axi_rdata[0])
    else $error("fixed bits of line control not one");
  mode_rsvd_a: assert property (s_axi_rvalid && ra_ff == 5'h04 |->
    s_axi_rdata[5:3] == 3'h7)
    else $error("fixed bits of mode not one");
  unmapped_a: assert property (s_axi_rvalid && ra_ff > 5'h10 |->
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h00000000)
    else $error("unmapped read not refused");
endmodule : ilmc_sva

bind ilmc_top ilmc_sva i_sva (.core_clk(core_clk), .resetn(resetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .scl_o(scl_o), .sda_o(sda_o));

// [test/ilmc_bus_partner.sv]
/*
  Behavioural two-wire slave: acknowledges after eight bits, may stretch SCL.
  Assumes resolved wire levels and the core clock for its own timing.
*/
`timescale 1ns/1ps
module ilmc_bus_partner
#(
  parameter int HOLD = 8,
  parameter int IDLE = 10,
  parameter int STR = 6
)
(
  input wire logic core_clk,
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_en,
  input wire logic stretch,
  output logic scl_oe,
  output logic sda_oe
);
  int n = 0;
  int hi = 0;
  int st = 0;
  int hd = 0;
  logic scl_q = 1'b1;
  initial sda_oe = 1'b0;
  assign scl_oe = st > 0;

  always @(posedge core_clk)
  begin
    scl_q <= scl;
    hi <= scl ? hi + 1 : 0;
    if (scl && hi > IDLE)
      n <= 0;
    if (scl && !scl_q)
      n <= n + 1;
    if (!scl && scl_q && stretch)
      st <= STR;
    else if (st > 0)
      st <= st - 1;
    // Pull SDA low for the acknowledge bit, release after a hold
    if (!scl && scl_q && n == 8 && ack_en)
    begin
      sda_oe <= 1'b1;
      hd <= 0;
    end
    else if (sda_oe && n == 9)
    begin
      hd <= hd + 1;
      if (hd == HOLD)
        sda_oe <= 1'b0;
    end
  end
endmodule : ilmc_bus_partner

// [test/testbench.sv]
/*
  Register-level testbench of ilmc_top with a two-wire slave partner.
  Assumes open-drain lines with pull-ups, resolved here.
*/
`timescale 1ns/1ps
module testbench;
  import ilmc_pkg::*;
  localparam int TICK = 2;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] awa, ara;
  logic [31:0] wd, rd;
  logic [3:0] ws;
  logic awv, wv, br, arv, rr, awr, wr, bv, arr, rv;
  logic [1:0] bresp, rresp;
  logic scl_o, sda_o, scl_oe, sda_oe, m_scl_oe, m_sda_oe, ack_en, stretch;
  logic scl_q = 1'b1;
  wire logic scl = !(scl_oe || m_scl_oe);
  wire logic sda = !(sda_oe || m_sda_oe);
  int n_mismatch = 0;
  int comparisons = 0;
  int run = 0;
  int lows[$];
  logic bits[$];
  int l0, l1, l2, l3;
  logic [31:0] v;

  ilmc_top #(.TICK_CYCLES(TICK)) i_dut (.core_clk(core_clk), .resetn(resetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe));
  ilmc_bus_partner i_partner (.core_clk(core_clk), .scl(scl), .sda(sda), .ack_en(ack_en),
    .stretch(stretch), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));

  always #4 core_clk = ~core_clk;

  // Records the SDA bit and the preceding SCL low time at each SCL rise
  always @(posedge core_clk)
  begin
    scl_q <= scl;
    if (!scl)
      run <= run + 1;
    else if (!scl_q)
    begin
      bits.push_back(sda);
      lows.push_back(run);
      run <= 0;
    end
  end

  task automatic close_out;
    if (n_mismatch == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic axw(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
    awa <= a;
    wd <= {24'h000000, d};
    ws <= 4'hF;
    awv <= 1'b1;
    wv <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (awr)
        awv <= 1'b0;
      if (wr)
        wv <= 1'b0;
    end while (!bv);
    cmp(32'(bresp), 32'(er));
  endtask : axw

  task automatic axr(input logic [4:0] a, output logic [31:0] d);
    ara <= a;
    arv <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (arr)
        arv <= 1'b0;
    end while (!rv);
    d = rd;
    cmp(32'(rresp), (a > 5'h10) ? 32'(RESP_SLVERR) : 32'(RESP_OKAY));
  endtask : axr

  task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
    logic [31:0] d;
    axr(a, d);
    cmp(d, {24'h000000, exp});
  endtask : rchk

  task automatic frame(input logic [7:0] ctl, input logic [7:0] mode, input logic [7:0] data,
                       output int mx);
    int nb, nl;
    logic [31:0] s;
    axw(5'h08, ctl, RESP_OKAY);
    axw(5'h04, mode, RESP_OKAY);
    axw(5'h0C, data, RESP_OKAY);
    nb = bits.size();
    nl = lows.size();
    axw(5'h08, ctl | 8'h04, RESP_OKAY);
    do
      axr(5'h10, s);
    while (s[0]);
    mx = 0;
    for (int i = nl; i < lows.size(); i++)
      if (lows[i] > mx)
        mx = lows[i];
    cmp(32'(bits.size() - nb), ctl[1] ? 32'h9 : 32'h8);
    for (int i = 0; i < 8; i++)
      cmp(32'(bits[nb + i]), 32'(mode[7] ? data[i] : data[7 - i]));
    if (ctl[1])
      cmp(32'(s[1]), 32'h1);
    axr(5'h0C, s);
    cmp(s, {24'h000000, data});
  endtask : frame

  initial
  begin
    {awa, ara, wd, ws} = '0;
    {awv, wv, arv, stretch} = '0;
    {br, rr} = 2'h3;
    ack_en = 1'b1;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    rchk(5'h00, 8'h7D);
    rchk(5'h04, 8'h38);
    axw(5'h00, 8'h10, RESP_OKAY);
    rchk(5'h00, 8'h7D);
    axw(5'h00, 8'h00, RESP_OKAY);
    rchk(5'h00, 8'h5D);
    cmp(32'(sda), 32'h0);
    axw(5'h00, 8'hE8, RESP_OKAY);
    rchk(5'h00, 8'h7D);
    cmp(32'({scl, sda}), 32'h3);
    axw(5'h04, 8'h05, RESP_OKAY);
    rchk(5'h04, 8'h3D);
    axw(5'h04, 8'h8B, RESP_OKAY);
    rchk(5'h04, 8'hBD);
    axw(5'h04, 8'h00, RESP_OKAY);
    axw(5'h14, 8'hFF, RESP_SLVERR);
    rchk(5'h14, 8'h00);
    frame(8'h03, 8'h08, 8'hA6, l0);
    frame(8'h03, 8'h48, 8'h3C, l1);
    cmp(32'(l1), 32'(l0 + 4 * TICK));
    ack_en <= 1'b0;
    frame(8'h01, 8'hC8, 8'hB1, l2);
    cmp(32'(l2), 32'(l0));
    ack_en <= 1'b1;
    // Slave frame with wait set: busy, but neither line is driven
    axw(5'h08, 8'h06, RESP_OKAY);
    axr(5'h10, v);
    cmp(32'(v[0]), 32'h1);
    cmp(32'({scl_oe, sda_oe}), 32'h0);
    axw(5'h00, 8'h22, RESP_OKAY);
    axw(5'h00, 8'h20, RESP_OKAY);
    // Control reset in the middle of a frame
    axw(5'h08, 8'h07, RESP_OKAY);
    axw(5'h00, 8'h22, RESP_OKAY);
    axr(5'h10, v);
    cmp(32'(v[0]), 32'h0);
    rchk(5'h04, 8'hF8);
    rchk(5'h00, 8'h7F);
    cmp(32'({scl_oe, sda_oe}), 32'h0);
    axw(5'h00, 8'h20, RESP_OKAY);
    // Let the partner see an idle bus before the next frame
    repeat (50) @(posedge core_clk);
    stretch <= 1'b1;
    frame(8'h03, 8'h08, 8'h5A, l3);
    stretch <= 1'b0;
    rchk(5'h04, 8'h38);
    close_out();
  end

  // About 500 cycles expected; the limit leaves ample margin
  initial
  begin
    #200000;
    n_mismatch++;
    close_out();
  end
endmodule : testbench
